// ===== src/bcd_clock_defines.vh
// constants for the bcd calendar clock core: register addresses, field positions,
// reset values and timing figures. assumes byte-wide special function register access.
`ifndef BCD_CLOCK_DEFINES_VH
`define BCD_CLOCK_DEFINES_VH

// register addresses on the special function register port
`define ADDR_CTRL_ONE      8'h00
`define ADDR_TRIM          8'h01
`define ADDR_CTRL_TWO      8'h02
`define ADDR_ALARM_SETUP   8'h03
`define ADDR_TIME_HIGH     8'h04
`define ADDR_TIME_LOW      8'h05
`define ADDR_ALARM_HIGH    8'h06
`define ADDR_ALARM_LOW     8'h07
`define ADDR_UNLOCK_KEY    8'h08

// clock_control_one fields
`define C1_RUN             7
`define C1_UNLOCK          5
`define C1_PENDING         4
`define C1_HALFSEC         3
`define C1_OUT_EN          2
`define C1_PTR_HI          1
`define C1_PTR_LO          0

// window pointer codes
`define PTR_MIN_SEC        2'b00
`define PTR_WDAY_HOUR      2'b01
`define PTR_MONTH_DAY      2'b10
`define PTR_YEAR           2'b11

// pin output select codes
`define SEL_ALARM_PULSE    2'b00
`define SEL_SECONDS        2'b01
`define SEL_OSC            2'b10

// unlock key bytes
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'haa

// bcd limits
`define BCD_SEC_MAX        8'h59
`define BCD_HOUR_MAX       8'h23
`define BCD_MONTH_MAX      8'h12
`define BCD_YEAR_MAX       8'h99
`define BCD_ZERO           8'h00
`define BCD_ONE            8'h01
`define WDAY_MAX           3'h6
`define DAY_31             8'h31
`define DAY_30             8'h30
`define DAY_29             8'h29
`define DAY_28             8'h28
`define MONTH_FEB          8'h02

// field masks so unimplemented bits read zero
`define MASK_SEVEN         8'h7f
`define MASK_SIX           8'h3f
`define MASK_FIVE          8'h1f
`define MASK_THREE         8'h07
`define MASK_TWO           8'h03

// reset values of control state and of the calendar (2000-01-01 00:00:00, sunday)
`define RST_BYTE           8'h00
`define RST_DAY            8'h01
`define RST_MONTH          8'h01

// timing: crystal rate, prescaler top, rollover guard and unlock window
`define OSC_HZ             32768
`define PRESCALE_TOP       16'sd32767
`define PRESCALE_HALF_BIT  14
`define PENDING_TICKS      16'sd32
`define UNLOCK_WINDOW      3'd4

`endif

// ===== src/unlock_sequencer.v
// unlock_sequencer: watches the unlock key port for the two-byte key sequence
// assumes key writes are single-cycle strobes synchronous to clk.
`include "bcd_clock_defines.vh"
`default_nettype none

module unlock_sequencer #(
  parameter [2:0] WINDOW = `UNLOCK_WINDOW
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // key port write
  input  wire       keyWrite,
  input  wire [7:0] keyData,
  // arm indication for the control register
  output reg        armed_q
);

  localparam [1:0] ST_IDLE  = 2'b00;
  localparam [1:0] ST_GOT1  = 2'b01;
  localparam [1:0] ST_ARMED = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [2:0] count_q;
  reg [2:0] count_d;

  // key sequence tracking; the arm lasts only a short window so stray writes cannot unlock
  always @* begin
    state_d = state_q;
    count_d = count_q;
    case (state_q)
      ST_IDLE: begin
        if (keyWrite && keyData == `KEY_FIRST) state_d = ST_GOT1;
      end
      ST_GOT1: begin
        if (keyWrite) begin
          if (keyData == `KEY_SECOND) begin
            state_d = ST_ARMED;
            count_d = WINDOW;
          end else if (keyData != `KEY_FIRST) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_ARMED: begin
        if (keyWrite && keyData == `KEY_FIRST) begin
          state_d = ST_GOT1;
        end else if (count_q == 3'd0) begin
          state_d = ST_IDLE;
        end else begin
          count_d = count_q - 3'd1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // state registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      count_q <= 3'd0;
      armed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      armed_q <= (state_d == ST_ARMED);
    end
  end

endmodule // unlock_sequencer

`default_nettype wire

// ===== src/bcd_calendar_clock_core.v
// bcd_calendar_clock_core: bcd time and calendar with windowed register access,
// write lock, drift trim and clock pin. assumes a byte special function register port
// and oscillator ticks given as one-cycle enables synchronous to clk.
`include "bcd_clock_defines.vh"
`default_nettype none

module bcd_calendar_clock_core #(
  parameter [2:0] UNLOCK_CYCLES = `UNLOCK_WINDOW
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // special function register port
  input  wire [7:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWrite,
  input  wire       regRead,
  output reg  [7:0] regRdata_q,
  // oscillator ticks and boot fuse
  input  wire       crystalTick,
  input  wire       lowFreqTick,
  input  wire       sourceSelectFuse,
  // clock output pin
  output reg        clockPin_q,
  output reg        clockPinEn_q
);

  // increment a bcd byte, wrapping from maxv to minv; bit 8 is the carry out
  function [8:0] incBcd;
    input [7:0] v;
    input [7:0] maxv;
    input [7:0] minv;
    begin
      if (v == maxv)
        incBcd = {1'b1, minv};
      else if (v[3:0] == 4'h9)
        incBcd = {1'b0, v[7:4] + 4'h1, 4'h0};
      else
        incBcd = {1'b0, v + 8'h01};
    end
  endfunction

  // leap year for a bcd year 00-99: divisible by four
  function isLeap;
    input [7:0] y;
    begin
      isLeap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    end
  endfunction

  // last day of a bcd month
  function [7:0] lastDay;
    input [7:0] m;
    input [7:0] y;
    begin
      case (m)
        8'h04, 8'h06, 8'h09, 8'h11: lastDay = `DAY_30;
        `MONTH_FEB:                 lastDay = isLeap(y) ? `DAY_29 : `DAY_28;
        default:                    lastDay = `DAY_31;
      endcase
    end
  endfunction

  // control registers
  reg        runEnable_q;
  reg        valueWriteUnlock_q;
  reg        outEnable_q;
  reg [1:0]  timePtr_q;
  reg [7:0]  driftTrim_q;
  reg [7:0]  ctrlTwo_q;
  reg [7:0]  alarmSetup_q;
  reg        pending_q;

  // calendar registers
  reg [7:0]  sec_q;
  reg [7:0]  min_q;
  reg [7:0]  hour_q;
  reg [2:0]  wday_q;
  reg [7:0]  day_q;
  reg [7:0]  month_q;
  reg [7:0]  year_q;
  reg [7:0]  sec_d;
  reg [7:0]  min_d;
  reg [7:0]  hour_d;
  reg [2:0]  wday_d;
  reg [7:0]  day_d;
  reg [7:0]  month_d;
  reg [7:0]  year_d;
  reg [8:0]  step;

  // alarm values, kept at implemented widths
  reg [6:0]  alarmMin_q;
  reg [6:0]  alarmSec_q;
  reg [2:0]  alarmWday_q;
  reg [5:0]  alarmHour_q;
  reg [4:0]  alarmMonth_q;
  reg [5:0]  alarmDay_q;

  // oscillator source and prescaler
  reg        fuseTaken_q;
  reg        useLowFreq_q;
  reg signed [15:0] prescale_q;
  reg        oscToggle_q;
  reg        secToggle_q;

  wire       armed;
  wire       oscTick;
  wire       secondTick;
  wire       minuteTick;
  wire       wrCtrlOne;
  wire       wrTimeHigh;
  wire       wrTimeLow;
  wire       timeWriteOk;
  wire       pairWrite;
  wire       accTimeHigh;
  wire       accAlarmHigh;
  wire       halfSec;
  wire [1:0] alarmPtr;
  wire [1:0] pinSelect;
  wire signed [15:0] trimLoad;

  unlock_sequencer #(
    .WINDOW   (UNLOCK_CYCLES)
  ) u_unlock (
    .clk      (clk),
    .rst      (rst),
    .keyWrite (regWrite && regAddr == `ADDR_UNLOCK_KEY),
    .keyData  (regWdata),
    .armed_q  (armed)
  );

  // source select: the fuse is a strap, caught by the first clock after reset release
  assign oscTick    = useLowFreq_q ? lowFreqTick : crystalTick;
  assign secondTick = runEnable_q && oscTick && prescale_q == `PRESCALE_TOP;
  assign minuteTick = secondTick && sec_q == `BCD_SEC_MAX;

  // trim times four, sign extended; a positive value starts the next second early
  assign trimLoad   = {{6{driftTrim_q[7]}}, driftTrim_q, 2'b00};

  assign halfSec    = prescale_q[`PRESCALE_HALF_BIT] & ~prescale_q[15];
  assign alarmPtr   = alarmSetup_q[1:0];
  assign pinSelect  = ctrlTwo_q[1:0];

  // decoded accesses
  assign wrCtrlOne    = regWrite && regAddr == `ADDR_CTRL_ONE;
  assign wrTimeHigh   = regWrite && regAddr == `ADDR_TIME_HIGH;
  assign wrTimeLow    = regWrite && regAddr == `ADDR_TIME_LOW;
  assign timeWriteOk  = valueWriteUnlock_q;
  assign pairWrite    = timeWriteOk && (wrTimeHigh || wrTimeLow) &&
                        timePtr_q == `PTR_MIN_SEC;
  assign accTimeHigh  = (regWrite || regRead) && regAddr == `ADDR_TIME_HIGH;
  assign accAlarmHigh = (regWrite || regRead) && regAddr == `ADDR_ALARM_HIGH;

  // fuse capture after reset release
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fuseTaken_q  <= 1'b0;
      useLowFreq_q <= 1'b0;
    end else if (!fuseTaken_q) begin
      fuseTaken_q  <= 1'b1;
      useLowFreq_q <= sourceSelectFuse;
    end
  end

  // prescaler: trim applied at each minute boundary, cleared by a minute-second write
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prescale_q <= 16'sd0;
    end else if (pairWrite) begin
      prescale_q <= 16'sd0;
    end else if (runEnable_q && oscTick) begin
      if (prescale_q == `PRESCALE_TOP)
        prescale_q <= minuteTick ? trimLoad : 16'sd0;
      else
        prescale_q <= prescale_q + 16'sd1;
    end
  end

  // rollover guard: high in the last ticks before a second boundary
  always @(posedge clk or posedge rst) begin
    if (rst)
      pending_q <= 1'b0;
    else
      pending_q <= runEnable_q && (prescale_q >= `PRESCALE_TOP - `PENDING_TICKS);
  end

  // calendar next state: carry chain first, then a same-cycle write overrides its field
  always @* begin
    sec_d   = sec_q;
    min_d   = min_q;
    hour_d  = hour_q;
    wday_d  = wday_q;
    day_d   = day_q;
    month_d = month_q;
    year_d  = year_q;
    step    = 9'h000;
    if (secondTick) begin
      step  = incBcd(sec_q, `BCD_SEC_MAX, `BCD_ZERO);
      sec_d = step[7:0];
      if (step[8]) begin
        step  = incBcd(min_q, `BCD_SEC_MAX, `BCD_ZERO);
        min_d = step[7:0];
        if (step[8]) begin
          step   = incBcd(hour_q, `BCD_HOUR_MAX, `BCD_ZERO);
          hour_d = step[7:0];
          if (step[8]) begin
            wday_d = (wday_q == `WDAY_MAX) ? 3'h0 : wday_q + 3'h1;
            step   = incBcd(day_q, lastDay(month_q, year_q), `BCD_ONE);
            day_d  = step[7:0];
            if (step[8]) begin
              step    = incBcd(month_q, `BCD_MONTH_MAX, `BCD_ONE);
              month_d = step[7:0];
              if (step[8]) begin
                step   = incBcd(year_q, `BCD_YEAR_MAX, `BCD_ZERO);
                year_d = step[7:0];
              end
            end
          end
        end
      end
    end
    // locked writes fall through untouched
    if (timeWriteOk && wrTimeHigh) begin
      case (timePtr_q)
        `PTR_MIN_SEC:   min_d   = regWdata & `MASK_SEVEN;
        `PTR_WDAY_HOUR: wday_d  = regWdata[2:0];
        `PTR_MONTH_DAY: month_d = regWdata & `MASK_FIVE;
        default:        min_d   = min_d;
      endcase
    end
    if (timeWriteOk && wrTimeLow) begin
      case (timePtr_q)
        `PTR_MIN_SEC:   sec_d  = regWdata & `MASK_SEVEN;
        `PTR_WDAY_HOUR: hour_d = regWdata & `MASK_SIX;
        `PTR_MONTH_DAY: day_d  = regWdata & `MASK_SIX;
        default:        year_d = regWdata;
      endcase
    end
  end

  // calendar registers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_q   <= `RST_BYTE;
      min_q   <= `RST_BYTE;
      hour_q  <= `RST_BYTE;
      wday_q  <= 3'h0;
      day_q   <= `RST_DAY;
      month_q <= `RST_MONTH;
      year_q  <= `RST_BYTE;
    end else begin
      sec_q   <= sec_d;
      min_q   <= min_d;
      hour_q  <= hour_d;
      wday_q  <= wday_d;
      day_q   <= day_d;
      month_q <= month_d;
      year_q  <= year_d;
    end
  end

  // control registers and window pointers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      runEnable_q        <= 1'b0;
      valueWriteUnlock_q <= 1'b0;
      outEnable_q        <= 1'b0;
      timePtr_q          <= `PTR_MIN_SEC;
      driftTrim_q        <= `RST_BYTE;
      ctrlTwo_q          <= `RST_BYTE;
      alarmSetup_q       <= `RST_BYTE;
    end else begin
      if (wrCtrlOne) begin
        if (valueWriteUnlock_q)
          runEnable_q <= regWdata[`C1_RUN];
        // unlock can always be dropped, but raised only while the key window is open
        if (!regWdata[`C1_UNLOCK])
          valueWriteUnlock_q <= 1'b0;
        else if (armed)
          valueWriteUnlock_q <= 1'b1;
        outEnable_q <= regWdata[`C1_OUT_EN];
        timePtr_q   <= regWdata[`C1_PTR_HI:`C1_PTR_LO];
      end else if (accTimeHigh && timePtr_q != `PTR_MIN_SEC) begin
        timePtr_q <= timePtr_q - 2'b01;
      end
      if (regWrite && regAddr == `ADDR_TRIM)
        driftTrim_q <= regWdata;
      if (regWrite && regAddr == `ADDR_CTRL_TWO)
        ctrlTwo_q <= regWdata;
      if (regWrite && regAddr == `ADDR_ALARM_SETUP)
        alarmSetup_q <= regWdata;
      else if (accAlarmHigh && alarmPtr != `PTR_MIN_SEC)
        alarmSetup_q[1:0] <= alarmPtr - 2'b01;
    end
  end

  // alarm values; minutes and seconds are always writable, the others need unlock
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      alarmMin_q   <= 7'h00;
      alarmSec_q   <= 7'h00;
      alarmWday_q  <= 3'h0;
      alarmHour_q  <= 6'h00;
      alarmMonth_q <= 5'h01;
      alarmDay_q   <= 6'h01;
    end else begin
      if (regWrite && regAddr == `ADDR_ALARM_HIGH) begin
        case (alarmPtr)
          `PTR_MIN_SEC:   alarmMin_q <= regWdata[6:0];
          `PTR_WDAY_HOUR: if (valueWriteUnlock_q) alarmWday_q <= regWdata[2:0];
          `PTR_MONTH_DAY: if (valueWriteUnlock_q) alarmMonth_q <= regWdata[4:0];
          default:        alarmMin_q <= alarmMin_q;
        endcase
      end
      if (regWrite && regAddr == `ADDR_ALARM_LOW) begin
        case (alarmPtr)
          `PTR_MIN_SEC:   alarmSec_q <= regWdata[6:0];
          `PTR_WDAY_HOUR: if (valueWriteUnlock_q) alarmHour_q <= regWdata[5:0];
          `PTR_MONTH_DAY: if (valueWriteUnlock_q) alarmDay_q <= regWdata[5:0];
          default:        alarmSec_q <= alarmSec_q;
        endcase
      end
    end
  end

  // read data: registered on the read strobe, unmapped addresses return zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata_q <= `RST_BYTE;
    end else if (regRead) begin
      case (regAddr)
        `ADDR_CTRL_ONE:
          regRdata_q <= {runEnable_q, 1'b0, valueWriteUnlock_q, pending_q,
                         halfSec, outEnable_q, timePtr_q};
        `ADDR_TRIM:        regRdata_q <= driftTrim_q;
        `ADDR_CTRL_TWO:    regRdata_q <= ctrlTwo_q;
        `ADDR_ALARM_SETUP: regRdata_q <= alarmSetup_q;
        `ADDR_TIME_HIGH: begin
          case (timePtr_q)
            `PTR_MIN_SEC:   regRdata_q <= min_q;
            `PTR_WDAY_HOUR: regRdata_q <= {5'h00, wday_q};
            `PTR_MONTH_DAY: regRdata_q <= month_q;
            default:        regRdata_q <= `RST_BYTE;
          endcase
        end
        `ADDR_TIME_LOW: begin
          case (timePtr_q)
            `PTR_MIN_SEC:   regRdata_q <= sec_q;
            `PTR_WDAY_HOUR: regRdata_q <= hour_q;
            `PTR_MONTH_DAY: regRdata_q <= day_q;
            default:        regRdata_q <= year_q;
          endcase
        end
        `ADDR_ALARM_HIGH: begin
          case (alarmPtr)
            `PTR_MIN_SEC:   regRdata_q <= {1'b0, alarmMin_q};
            `PTR_WDAY_HOUR: regRdata_q <= {5'h00, alarmWday_q};
            `PTR_MONTH_DAY: regRdata_q <= {3'h0, alarmMonth_q};
            default:        regRdata_q <= `RST_BYTE;
          endcase
        end
        `ADDR_ALARM_LOW: begin
          case (alarmPtr)
            `PTR_MIN_SEC:   regRdata_q <= {1'b0, alarmSec_q};
            `PTR_WDAY_HOUR: regRdata_q <= {2'h0, alarmHour_q};
            `PTR_MONTH_DAY: regRdata_q <= {2'h0, alarmDay_q};
            default:        regRdata_q <= `RST_BYTE;
          endcase
        end
        default: regRdata_q <= `RST_BYTE;
      endcase
    end
  end

  // clock pin: toggles make a 50% wave at half the event rate; no alarm pulse
  // is generated anywhere in the core, so that selection drives low here
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      oscToggle_q  <= 1'b0;
      secToggle_q  <= 1'b0;
      clockPin_q   <= 1'b0;
      clockPinEn_q <= 1'b0;
    end else begin
      if (lowFreqTick)
        oscToggle_q <= ~oscToggle_q;
      if (secondTick)
        secToggle_q <= ~secToggle_q;
      clockPinEn_q <= outEnable_q;
      case (pinSelect)
        `SEL_SECONDS: clockPin_q <= outEnable_q & secToggle_q;
        `SEL_OSC:     clockPin_q <= outEnable_q & useLowFreq_q & oscToggle_q;
        default:      clockPin_q <= 1'b0;
      endcase
    end
  end

endmodule // bcd_calendar_clock_core

`default_nettype wire

// ===== bench/bcd_clock_monitor.sv
// port-level checks for the bcd calendar clock core.
// assumes the core's single clock and active-high async reset.
`default_nettype none

module bcd_clock_monitor (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdata_q,
  // ticks and pin
  input wire logic       crystalTick,
  input wire logic       lowFreqTick,
  input wire logic       sourceSelectFuse,
  input wire logic       clockPin_q,
  input wire logic       clockPinEn_q
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // window and control reads: unused upper bits stay zero, digits stay decimal
  AST_ALARM_HIGH_FMT: assert property (regRead && regAddr == 8'h06 |=>
    !regRdata_q[7] && regRdata_q[6:4] <= 3'h5) else $error("alarm high format");
  AST_ALARM_LOW_FMT: assert property (regRead && regAddr == 8'h07 |=>
    !regRdata_q[7]) else $error("alarm low top bit set");
  AST_TIME_HIGH_FMT: assert property (regRead && regAddr == 8'h04 |=>
    regRdata_q[7:4] <= 4'h5) else $error("time high tens out of range");
  AST_TIME_DIGIT: assert property ((regRead && regAddr[7:1] == 7'h02) |=>
    regRdata_q[3:0] <= 4'h9) else $error("time ones digit past nine");
  AST_ALARM_DIGIT: assert property ((regRead && regAddr[7:1] == 7'h03) |=>
    regRdata_q[3:0] <= 4'h9) else $error("alarm ones digit past nine");
  AST_CTRL_SPARE: assert property (regRead && regAddr == 8'h00 |=>
    !regRdata_q[6]) else $error("control spare bit set");
  // the pin only drives while enabled
  AST_PIN_GATED: assert property (clockPin_q |-> clockPinEn_q)
    else $error("pin active while disabled");
  // read data holds between reads so a double read can compare
  AST_RDATA_HOLDS: assert property (!regRead |=> $stable(regRdata_q))
    else $error("read data moved without a read");
endmodule // bcd_clock_monitor

bind bcd_calendar_clock_core bcd_clock_monitor bcd_clock_monitor_inst (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
  .regRead(regRead), .regRdata_q(regRdata_q), .crystalTick(crystalTick),
  .lowFreqTick(lowFreqTick), .sourceSelectFuse(sourceSelectFuse),
  .clockPin_q(clockPin_q), .clockPinEn_q(clockPinEn_q)
);
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench for the bcd calendar clock core.
// assumes one crystal tick per cycle while counting, so a second is 32768 cycles.
`default_nettype none

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin nMismatch++; \
  $display("[ERR] %0t got %h expected %h", $time, (a), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk;
  logic       rst;
  logic [7:0] regAddr;
  logic [7:0] regWdata;
  logic       regWrite;
  logic       regRead;
  logic [7:0] regRdata_q;
  logic       crystalTick;
  logic       lowFreqTick;
  logic       sourceSelectFuse;
  logic       clockPin_q;
  logic       clockPinEn_q;
  logic       p;
  int         nMismatch = 0;
  int         comparisons = 0;
  // rows: {write, address, data}; for reads data is the expected value
  logic [16:0] tbl [0:90] = '{
    17'h00000, 17'h10080, 17'h00000, 17'h10533, 17'h00500, 17'h00900, 17'h1017f, 17'h0017f,
    17'h10855, 17'h108aa, 17'h10023, 17'h10599, 17'h10400, 17'h10531, 17'h10412, 17'h10523,
    17'h10406, 17'h10559, 17'h10459, 17'h10301, 17'h10721, 17'h10605, 17'h107d9, 17'h106b7,
    17'h10301, 17'h00721, 17'h00605, 17'h00759, 17'h00637, 17'h00637, 17'h10855, 17'h108aa,
    17'h10023, 17'h00599, 17'h00400, 17'h00531, 17'h00412, 17'h00523, 17'h00406, 17'h00559,
    17'h00459, 17'h10855, 17'h108aa, 17'h100a0, 17'h000a0, 17'h000a8, 17'h000b8, 17'h10855,
    17'h108aa, 17'h100a3, 17'h00500, 17'h00400, 17'h00501, 17'h00401, 17'h00500, 17'h00400,
    17'h00500, 17'h00400, 17'h00500, 17'h00501, 17'h10855, 17'h108aa, 17'h10023, 17'h10504,
    17'h10400, 17'h10528, 17'h10402, 17'h10523, 17'h10406, 17'h10559, 17'h10459, 17'h10855,
    17'h108aa, 17'h100a0, 17'h00559, 17'h10855, 17'h108aa, 17'h100a3, 17'h00504, 17'h00400,
    17'h00529, 17'h00402, 17'h00500, 17'h00400, 17'h00500, 17'h00400, 17'h00000, 17'h10202,
    17'h10004, 17'h00202, 17'h00004};

  bcd_calendar_clock_core bcd_calendar_clock_core_inst (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata_q(regRdata_q), .crystalTick(crystalTick),
    .lowFreqTick(lowFreqTick), .sourceSelectFuse(sourceSelectFuse),
    .clockPin_q(clockPin_q), .clockPinEn_q(clockPinEn_q)
  );

  task automatic close_out;
    if (nMismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one register access; strobes stay up between writes so none is assigned twice a step
  task automatic acc(input logic [16:0] op);
    regAddr  <= op[15:8];
    regWdata <= op[7:0];
    regWrite <= op[16];
    regRead  <= !op[16];
    @(posedge clk);
    if (!op[16]) begin
      regRead <= 1'b0;
      @(negedge clk);
      `CHK(regRdata_q, op[7:0])
      @(posedge clk);
    end
  endtask

  task automatic run(input int a, input int b);
    for (int i = a; i <= b; i++) acc(tbl[i]);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
  endtask

  // n crystal ticks back to back; ticks stop during register accesses
  task automatic tick(input int n);
    crystalTick <= 1'b1;
    repeat (n) @(posedge clk);
    crystalTick <= 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // limit covers about three counted seconds of ticks plus register traffic
  initial begin
    repeat (99500) @(posedge clk);
    nMismatch++;
    close_out;
  end

  initial begin
    rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    crystalTick = 1'b0;
    lowFreqTick = 1'b0;
    sourceSelectFuse = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    // locked writes, set 99-12-31 23:59:59 saturday, alarm window, start
    run(0, 44);
    tick(16384);
    run(45, 45);
    tick(16356);
    run(46, 46);
    tick(28);
    run(47, 57);
    // trim 7f shortens the next second to 32768 - 508 ticks
    tick(32259);
    run(58, 58);
    tick(1);
    run(59, 59);
    tick(100);
    // leap february; the minute write must clear the stale prescaler
    run(60, 73);
    tick(32767);
    run(74, 74);
    tick(1);
    run(75, 85);
    // second reset with the low-frequency oscillator chosen and routed to the pin
    sourceSelectFuse <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    run(86, 90);
    repeat (2) begin
      @(negedge clk);
      p = clockPin_q;
      @(posedge clk);
      lowFreqTick <= 1'b1;
      @(posedge clk);
      lowFreqTick <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(clockPin_q, ~p)
      `CHK(clockPinEn_q, 1'b1)
    end
    close_out;
  end
endmodule // tb
`default_nettype wire
